// >>> core/pwm_pkg.sv
package pwm_pkg;
	// Byte offsets of the global registers
	localparam logic [11:0] OFF_MODE    = 12'h000;
	localparam logic [11:0] OFF_ON_SET  = 12'h004;
	localparam logic [11:0] OFF_ON_CLR  = 12'h008;
	localparam logic [11:0] OFF_STATUS  = 12'h00c;
	localparam logic [11:0] OFF_IRQ_SET = 12'h010;
	localparam logic [11:0] OFF_IRQ_CLR = 12'h014;
	localparam logic [11:0] OFF_IRQ_MSK = 12'h018;
	localparam logic [11:0] OFF_IRQ_FLG = 12'h01c;
	// Channel register window: base plus channel times stride
	localparam logic [11:0] OFF_CH_BASE = 12'h200;
	localparam int          CH_SHIFT    = 5;
	localparam logic [4:0]  CH_MODE     = 5'h00;
	localparam logic [4:0]  CH_DUTY     = 5'h04;
	localparam logic [4:0]  CH_PERIOD   = 5'h08;
	localparam logic [4:0]  CH_COUNT    = 5'h0c;
	localparam logic [4:0]  CH_UPDATE   = 5'h10;
	localparam int          NUM_CH      = 4;
	// Channel mode field positions
	localparam int          MODE_SEL_LSB = 0;
	localparam int          MODE_ALIGN   = 8;
	localparam int          MODE_START   = 9;
	localparam int          MODE_TARGET  = 10;
	// Global mode field positions (divider A and B)
	localparam int          DIVIDER_A_FACTOR_LSB = 0;
	localparam int          PREA_LSB = 8;
	localparam int          DIVIDER_B_FACTOR_LSB = 16;
	localparam int          PREB_LSB = 24;
	// Clock select codes
	localparam logic [3:0]  SEL_MAX_POW = 4'ha;
	localparam logic [3:0]  SEL_CLK_A   = 4'hb;
	localparam logic [3:0]  SEL_CLK_B   = 4'hc;
	// Reset values
	localparam logic [15:0] RESET_VALUE = 16'h0000;
endpackage : pwm_pkg

// >>> core/four_channel_pwm_regs.sv
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
// Summary of operation
// - Status bits show which channels run
// - Enable-set write of 1 unmasks interrupt
// - Enable-clear write of 1 masks interrupt
// - Mask view reads current enabled interrupts
// - Flag set after each completed period
// - Reading flags clears those it returned
// - Clock select: SYSTEM_MASTER_CLOCK/2^n, clock A, B
// - Alignment bit: left or center
// - Start level bit sets initial output
// - Target bit routes update to duty/period
// - Duty and period keep 16 bits
// - Left period is value times prescale
// - Center period doubles left period
// - Divided clocks scale period likewise
// - Counter clears on enable, left wrap
// - Update held until period end
// - On-set/on-clear writes start, stop channels
module four_channel_pwm_regs
	import pwm_pkg::*;
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Waveforms and interrupt
	output logic      [3:0]  pwm_out,
	output logic             irq
);

	// Bus timing
	// Read data is captured from the registers in the setup cycle.
	// It stands in prdata through the access cycle, so zero wait
	// states are kept while prdata still comes from a flip-flop.
	// After the access edge prdata returns to zero.
	// Writes take effect at the access edge only.
	// Unmapped places read zero and ignore writes; no error is given.

	// Flag clearing
	// Only the flags reported in the captured read data are cleared.
	// A period end between capture and access survives the read,
	// so no completion is ever lost to a racing read.
	// A period end in the access cycle itself also wins over the clear.

	// Channel engine
	// Each channel owns a free-running prescale chain.
	// A power-of-two code ticks when the low chain bits are all ones.
	// Codes for divided clocks A and B take the shared divider pulses.
	// Reserved codes give no tick, so the counter simply stops.
	// Left alignment counts 0 up to period minus one, then wraps.
	// Center alignment counts up to the period and back down to zero,
	// which doubles the output period for the same period value.
	// A period ends at the wrap to zero in either alignment.

	// Waveform
	// The output holds the start level while the counter is below duty.
	// It shows the inverse level for the rest of the period.
	// A stopped channel rests at its start level.
	// Changing start level or alignment while running may glitch;
	// software is expected to stop the channel first.

	// Updates
	// A write to the update place is held with a pending flag.
	// At the next period end it lands in duty or period, by target bit.
	// A second update before that end replaces the first one.
	// Writing duty or period directly takes effect at once.

	// Dividers
	// Each divider counts prescaled ticks up to its factor.
	// A factor of zero turns the divided clock off.
	// A factor of one passes the prescaled tick straight through.
	// The divider prescale chain runs free and is shared by both.

	// Interrupt
	// The interrupt line is the OR of flags gated by the mask.
	// It is a pure function of registers, so it cannot glitch on reads.

	// Per-channel state
	typedef struct packed {
		logic [10:0] mode;      // Target, start, align, 4 unused, select
		logic [15:0] duty;      // Active duty value
		logic [15:0] period;    // Active period value
		logic [15:0] count;     // Channel counter
		logic        down;      // Center mode counting down
		logic [15:0] pending;   // Held update value
		logic        pend_ok;   // Update waiting for period end
		logic [10:0] presc;     // Master clock prescale chain
		logic        wave;      // Registered waveform level
	} chan_t;

	// Whole block state
	typedef struct packed {
		logic [31:0] gmode;     // Divider A/B setup
		logic [7:0]  div_a;     // Divider A counter
		logic [7:0]  div_b;     // Divider B counter
		logic        tick_a;    // Divided clock A pulse
		logic        tick_b;    // Divided clock B pulse
		logic [3:0]  on;        // Channel running
		logic [3:0]  mask;      // Interrupt enabled
		logic [3:0]  flags;     // Period-done flags
		logic [31:0] rdata;     // Read data register
		chan_t [3:0] ch;        // Channels
	} state_t;

	state_t st;            // Current state
	state_t next_st;       // Next state

	// Unit prescaler tick for a power-of-two divider selection
	function automatic logic pow_tick(input logic [10:0] chain,
		input logic [3:0] code);
		logic t;
		t = 1'b0;
		if (code == 4'h0) begin
			t = 1'b1;
		end else begin
			// All lower bits ones means the bit of that weight rolls over
			t = &(chain | ~((11'h001 << code) - 11'h001));
		end
		return t;
	endfunction : pow_tick

	// Prescaler tick for divider A/B from the master prescale chain
	function automatic logic div_in(input logic [10:0] chain,
		input logic [3:0] pre);
		logic t;
		t = 1'b0;
		if (pre <= SEL_MAX_POW) begin
			t = pow_tick(chain, pre);
		end
		return t;
	endfunction : div_in

	// Global prescale chain shared by the dividers
	logic [10:0] gchain;       // Free-running master clock chain
	logic [10:0] next_gchain;  // Next chain value

	// Bus decode
	logic        acc;          // Access phase
	logic        wr;           // Write taking effect
	logic        rd;           // Read setup: read data is captured
	logic        rd_done;      // Read access edge: flags may clear
	logic        in_ch;        // Address in channel window
	logic [1:0]  ch_idx;       // Addressed channel
	logic [4:0]  ch_off;       // Offset inside channel window

	always_comb begin
		acc    = psel & penable;
		wr     = acc & pwrite;
		rd     = psel & ~penable & ~pwrite;
		rd_done = acc & ~pwrite;
		in_ch  = (paddr[11:7] == OFF_CH_BASE[11:7]);
		ch_idx = paddr[6:5];
		ch_off = paddr[4:0];
	end

	// Zero wait states, no error responses
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = st.rdata;
	assign irq     = |(st.flags & st.mask);

	always_comb begin
		pwm_out = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			pwm_out[i] = st.ch[i].wave;
		end
	end

	// Next-state logic for all registers and channels
	always_comb begin
		logic        tick;
		logic        pend_end;
		logic [7:0]  dv;
		logic [15:0] cnt;
		logic [3:0]  sets;
		sets        = 4'h0;
		next_st     = st;
		tick        = 1'b0;
		pend_end    = 1'b0;
		dv          = 8'h00;
		cnt         = 16'h0000;
		next_gchain = gchain + 11'h001;
		next_st.rdata = 32'h0000_0000;

		// Divided clocks A and B; factor zero stops them
		next_st.tick_a = 1'b0;
		dv = st.gmode[DIVIDER_A_FACTOR_LSB +: 8];
		if (dv != 8'h00 && div_in(gchain, st.gmode[PREA_LSB +: 4])) begin
			if (st.div_a + 8'h01 >= dv) begin
				next_st.div_a  = 8'h00;
				next_st.tick_a = 1'b1;
			end else begin
				next_st.div_a = st.div_a + 8'h01;
			end
		end
		next_st.tick_b = 1'b0;
		dv = st.gmode[DIVIDER_B_FACTOR_LSB +: 8];
		if (dv != 8'h00 && div_in(gchain, st.gmode[PREB_LSB +: 4])) begin
			if (st.div_b + 8'h01 >= dv) begin
				next_st.div_b  = 8'h00;
				next_st.tick_b = 1'b1;
			end else begin
				next_st.div_b = st.div_b + 8'h01;
			end
		end

		// Channel engines
		for (int i = 0; i < NUM_CH; i++) begin
			next_st.ch[i].presc = st.ch[i].presc + 11'h001;
			// Counter clock selection
			unique case (st.ch[i].mode[3:0])
				SEL_CLK_A: tick = st.tick_a;
				SEL_CLK_B: tick = st.tick_b;
				default: begin
					// Reserved codes stop the counter
					tick = (st.ch[i].mode[3:0] <= SEL_MAX_POW) &&
						pow_tick(st.ch[i].presc, st.ch[i].mode[3:0]);
				end
			endcase
			pend_end = 1'b0;
			cnt = st.ch[i].count;
			if (st.on[i] && tick) begin
				if (!st.ch[i].mode[MODE_ALIGN]) begin
					// Left aligned: period ticks per cycle
					if (cnt + 16'h0001 >= st.ch[i].period) begin
						cnt = 16'h0000;
						pend_end = 1'b1;
					end else begin
						cnt = cnt + 16'h0001;
					end
				end else if (!st.ch[i].down) begin
					// Center aligned: up then down, twice as long
					if (cnt + 16'h0001 >= st.ch[i].period) begin
						next_st.ch[i].down = 1'b1;
						cnt = st.ch[i].period;
					end else begin
						cnt = cnt + 16'h0001;
					end
				end else begin
					if (cnt <= 16'h0001) begin
						cnt = 16'h0000;
						next_st.ch[i].down = 1'b0;
						pend_end = 1'b1;
					end else begin
						cnt = cnt - 16'h0001;
					end
				end
			end
			next_st.ch[i].count = cnt;
			// Start level for the first part, inverse after duty
			next_st.ch[i].wave = st.on[i] &
				((cnt < st.ch[i].duty) ~^ st.ch[i].mode[MODE_START]) ^
				~st.on[i] & st.ch[i].mode[MODE_START];
			if (!st.on[i]) begin
				next_st.ch[i].wave = st.ch[i].mode[MODE_START];
			end
			if (pend_end) begin
				next_st.flags[i] = 1'b1;
				sets[i] = 1'b1;
				// Held update lands at period end
				if (st.ch[i].pend_ok) begin
					next_st.ch[i].pend_ok = 1'b0;
					if (st.ch[i].mode[MODE_TARGET]) begin
						next_st.ch[i].period = st.ch[i].pending;
					end else begin
						next_st.ch[i].duty = st.ch[i].pending;
					end
				end
			end
		end

		// Flags clear at the read's access edge; a new set wins
		if (rd_done && !in_ch && paddr == OFF_IRQ_FLG) begin
			next_st.flags = (st.flags & ~st.rdata[3:0]) | sets;
		end
		// Read data captured in the setup cycle
		if (rd && !in_ch) begin
			unique case (paddr)
				OFF_MODE:    next_st.rdata = st.gmode;
				OFF_IRQ_FLG: next_st.rdata = {28'h0, st.flags};
				OFF_STATUS:  next_st.rdata = {28'h0, st.on};
				OFF_IRQ_MSK: next_st.rdata = {28'h0, st.mask};
				default:     next_st.rdata = 32'h0000_0000;
			endcase
		end else if (rd && in_ch) begin
			unique case (ch_off)
				CH_MODE:   next_st.rdata = {21'h0, st.ch[ch_idx].mode};
				CH_DUTY:   next_st.rdata = {16'h0, st.ch[ch_idx].duty};
				CH_PERIOD: next_st.rdata = {16'h0, st.ch[ch_idx].period};
				CH_COUNT:  next_st.rdata = {16'h0, st.ch[ch_idx].count};
				default:   next_st.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes
		if (wr && !in_ch) begin
			unique case (paddr)
				OFF_MODE:    next_st.gmode = pwdata;
				OFF_ON_SET: begin
					next_st.on = st.on | pwdata[3:0];
					for (int i = 0; i < NUM_CH; i++) begin
						if (pwdata[i]) begin
							next_st.ch[i].count = 16'h0000;
							next_st.ch[i].down  = 1'b0;
						end
					end
				end
				OFF_ON_CLR:  next_st.on = st.on & ~pwdata[3:0];
				OFF_IRQ_SET: next_st.mask = st.mask | pwdata[3:0];
				OFF_IRQ_CLR: next_st.mask = st.mask & ~pwdata[3:0];
				default: ;
			endcase
		end else if (wr && in_ch) begin
			// Duty, period and update keep 16 bits; mode keeps 7
			unique case (ch_off)
				CH_MODE: begin
					next_st.ch[ch_idx].mode = {pwdata[10:8], 4'h0,
						pwdata[3:0]};
				end
				CH_DUTY:   next_st.ch[ch_idx].duty   = pwdata[15:0];
				CH_PERIOD: next_st.ch[ch_idx].period = pwdata[15:0];
				CH_UPDATE: begin
					next_st.ch[ch_idx].pending = pwdata[15:0];
					next_st.ch[ch_idx].pend_ok = 1'b1;
				end
				default: ;
			endcase
		end
	end

	// State registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st     <= '0;
			gchain <= 11'h000;
		end else begin
			st     <= next_st;
			gchain <= next_gchain;
		end
	end

endmodule : four_channel_pwm_regs

// >>> verif/pwm_regs_properties.sv
`timescale 1ns/1ps
module pwm_regs_properties
	import pwm_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Waveforms and interrupt
	input wire logic [3:0]  pwm_out,
	input wire logic        irq
);
	logic       acc;    // Completed access
	logic       rd;     // Completed read
	logic       ch;     // Address in the channel window
	logic [3:0] mask_q; // Shadow of the interrupt mask
	assign acc = psel && penable && pready;
	assign rd  = acc && !pwrite;
	assign ch  = paddr[11:7] == 5'h04;
	// Shadow mask, so the view can be judged without the body
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q <= 4'h0;
		end else if (acc && pwrite && paddr == OFF_IRQ_SET) begin
			mask_q <= mask_q | pwdata[3:0];
		end else if (acc && pwrite && paddr == OFF_IRQ_CLR) begin
			mask_q <= mask_q & ~pwdata[3:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_STATUS_BITS: assert property (
		rd && paddr == OFF_STATUS |-> prdata[31:4] == 28'h0)
		else $error("status upper bits set");
	AST_MASK_VIEW: assert property (
		rd && paddr == OFF_IRQ_MSK |-> prdata == {28'h0, mask_q})
		else $error("mask view differs");
	AST_FLAG_BITS: assert property (
		rd && paddr == OFF_IRQ_FLG |-> prdata[31:4] == 28'h0)
		else $error("flag upper bits set");
	AST_WIDTH16: assert property (
		rd && ch && (paddr[4:0] == CH_DUTY || paddr[4:0] == CH_PERIOD)
		|-> prdata[31:16] == 16'h0)
		else $error("duty or period wider than 16 bits");
	AST_MODE_BITS: assert property (
		rd && ch && paddr[4:0] == CH_MODE
		|-> prdata[31:11] == 21'h0 && prdata[7:4] == 4'h0)
		else $error("mode reserved bits set");
	AST_MASK_OFF: assert property (
		acc && pwrite && paddr == OFF_IRQ_CLR && pwdata[3:0] == 4'hf
		|=> !irq [*2])
		else $error("irq with all masked");
	AST_IRQ_NEEDS_MASK: assert property (
		irq |-> mask_q != 4'h0)
		else $error("irq while masked");
	AST_SET_UNMASK: assert property (
		acc && pwrite && paddr == OFF_IRQ_SET && pwdata[3:0] == 4'hf
		##[2:3] rd && paddr == OFF_IRQ_MSK |-> prdata[3:0] == 4'hf)
		else $error("set did not unmask");
endmodule : pwm_regs_properties
bind four_channel_pwm_regs pwm_regs_properties pwm_regs_properties_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));

// >>> verif/four_channel_pwm_regs_test.sv
`timescale 1ns/1ps
module four_channel_pwm_regs_test;
	import pwm_pkg::*;
	// APB and reset
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	// Design outputs
	logic [31:0] prdata;
	logic        pready, pslverr, irq;
	logic [3:0]  pwm_out;
	// Bookkeeping
	int          errors, n_tests, seed, per, hi;
	logic [31:0] rv, a, b;
	four_channel_pwm_regs four_channel_pwm_regs_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pwm_out(pwm_out), .irq(irq));
	// Clock at 4 ns
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Channel register address
	function automatic logic [11:0] ca(input int c, input logic [4:0] o);
		return OFF_CH_BASE + 12'(c << CH_SHIFT) + 12'(o);
	endfunction : ca
	// Expected ticks per period; divider A is 3, divider B is 4
	function automatic int ep(input int s, input int al, input int p);
		return (al + 1) * p * ((s <= 10) ? (1 << s) : (s == 11) ? 3 : 4);
	endfunction : ep
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; read data is taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] ad, input int d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w) begin
			rv = prdata;
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// High time and full period of one waveform, from a rising edge
	task automatic meas(input int c);
		while (pwm_out[c] !== 1'b0) @(posedge pclk);
		while (pwm_out[c] !== 1'b1) @(posedge pclk);
		hi = 0;
		per = 0;
		while (pwm_out[c] === 1'b1) begin
			@(posedge pclk);
			hi++;
		end
		while (pwm_out[c] !== 1'b1) begin
			@(posedge pclk);
			per++;
		end
		per += hi;
	endtask : meas
	task automatic conclude;
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	// Hang guard, well beyond the expected run
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		conclude();
	end
	// Main sequence
	initial begin
		int s[5], al[5], p[5];
		s = '{0, 1, 2, 11, 12};
		al = '{0, 0, 1, 0, 0};
		p = '{10, 6, 5, 4, 3};
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		seed = 79;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, plus an unmapped place that reads 0
		foreach (s[i]) begin
			apb(0, (i < 4) ? OFF_STATUS + 12'(i * 4) : 12'h100, 0);
			chk("reset", rv, 0);
		end
		// Random register traffic; duty is kept within period
		for (int c = 0; c < 4; c++) begin
			a = $random(seed);
			b = $random(seed);
			apb(1, ca(c, CH_PERIOD), a);
			apb(1, ca(c, CH_DUTY), a & b);
			apb(0, ca(c, CH_PERIOD), 0);
			chk("period", rv, a & 32'hffff);
			apb(0, ca(c, CH_DUTY), 0);
			chk("duty", rv, a & b & 32'hffff);
			apb(1, ca(c, CH_MODE), b);
			apb(0, ca(c, CH_MODE), 0);
			chk("mode", rv, b & 32'h70f);
			apb(1, OFF_IRQ_CLR, 32'hf);
			apb(1, OFF_IRQ_SET, a);
			apb(1, OFF_IRQ_CLR, b);
			apb(1, OFF_IRQ_SET, 0);
			apb(0, OFF_IRQ_MSK, 0);
			chk("mask", rv, a & ~b & 32'hf);
			apb(1, OFF_ON_SET, b);
			apb(0, OFF_STATUS, 0);
			chk("status", rv, b & 32'hf);
			apb(1, OFF_ON_CLR, 32'hf);
		end
		// Periods for each clock source and alignment, both start levels
		apb(1, OFF_MODE, 32'h01020003);
		foreach (s[i]) begin
			// Mode is only changed while the channel is stopped
			apb(1, ca(i % 4, CH_MODE),
				s[i] | (al[i] << 8) | ((i % 2) << 9));
			apb(1, ca(i % 4, CH_DUTY), 1);
			apb(1, ca(i % 4, CH_PERIOD), p[i]);
			apb(1, OFF_ON_SET, 1 << (i % 4));
			meas(i % 4);
			chk("ticks", per, ep(s[i], al[i], p[i]));
			if (al[i] == 0)
				chk("high", hi, (i % 2) ? ep(s[i], 0, 1) : ep(s[i], 0, p[i] - 1));
			apb(1, OFF_ON_CLR, 1 << (i % 4));
		end
		// Flags, interrupt line and clear on read
		apb(1, OFF_ON_SET, 1);
		apb(1, OFF_IRQ_CLR, 32'hf);
		apb(1, OFF_IRQ_SET, 32'hf);
		apb(0, OFF_IRQ_MSK, 0);
		repeat (30) @(posedge pclk);
		chk("irq", irq, 1);
		apb(0, OFF_IRQ_FLG, 0);
		chk("flag", rv[0], 1);
		apb(1, OFF_ON_CLR, 1);
		apb(0, OFF_IRQ_FLG, 0);
		apb(0, OFF_IRQ_FLG, 0);
		chk("flags", rv, 0);
		chk("irq clear", irq, 0);
		// Double-buffered update, duty then period
		apb(1, ca(1, CH_MODE), 0);
		apb(1, ca(1, CH_DUTY), 2);
		apb(1, ca(1, CH_PERIOD), 200);
		apb(1, OFF_ON_SET, 2);
		meas(1);
		apb(1, ca(1, CH_UPDATE), 50);
		apb(0, ca(1, CH_DUTY), 0);
		chk("held", rv, 2);
		meas(1);
		chk("new high", hi, 150);
		apb(1, ca(1, CH_MODE), 32'h400);
		apb(1, ca(1, CH_UPDATE), 100);
		meas(1);
		meas(1);
		chk("new ticks", per, 100);
		conclude();
	end
endmodule : four_channel_pwm_regs_test
